/* File: hdl/glpc_top.sv */
// glpc_top.sv: configuration and pin muxing for three shared pins
// (gpio, link indicator, time event output) behind an avalon-mm slave
// assumes link status, activity and event channels are synchronous to clk_sys_i
//
// What this block does
// - bits 10:8 of the indicator register pick which link indication enabled pins show.
// - the selected indication reaches a pin only while that pin's indicator enable is set.
// - bits 2:0 of the indicator register set each pin as gpio (0) or indicator (1).
// - indicator pins are open-drain style with their pull-up and input buffer off.
// - indicator polarity comes from the strap latched on the first clock after reset, high meaning active low.
// - function select and enable load the values on their strap inputs on the first clock after reset.
// - bits 26:24 of the pin register route event channel A (0) or B (1) per pin.
// - bits 18:16 of the pin register select low (0) or high (1) level per pin.
// - a pin's interrupt status sets while its input sits at the selected level, unless its indicator enable is set.
// - clock events are driven at the level given by the pin's polarity bit.
// - the polarity bit is also the active level of the timer clear input.
// - bits 10:8 of the pin register enable clock event output per pin.
// - an event-enabled gpio pin is an output whatever its direction, keeping its driver type.
// - activity shows as an 80 ms active pulse (functions 2-4) or an 80 ms gap in the link indication (0, 1), at least 80 ms apart.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`include "glpc_params.svh"
module glpc_top #(
    parameter int unsigned ACT_CYC = `GLPC_ACT_MS * 1000 * `GLPC_CLK_MHZ
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // avalon-mm slave
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    // straps
    input wire logic [2:0] indicator_function_strap_i,
    input wire logic [2:0] indicator_enable_strap_i,
    input wire logic [2:0] indicator_polarity_strap_i,
    // link status
    input wire logic link_up_i,
    input wire logic speed_100_i,
    input wire logic full_duplex_i,
    input wire logic activity_i,
    input wire logic collision_i,
    // time events
    input wire logic [2:0] event_chan_a_i,
    input wire logic [2:0] event_chan_b_i,
    output logic [2:0] timer_clear_o,
    // pins
    input wire logic [2:0] pin_i,
    output logic [2:0] pin_o,
    output logic [2:0] pin_oe_o,
    output logic [2:0] pin_pullup_en_o,
    output logic [2:0] pin_inbuf_en_o
);
    initial begin
        if (ACT_CYC < 1) $error("glpc_top: ACT_CYC must be at least one");
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [2:0] indicator_function_sel_r;
    logic [2:0] indicator_enable_r;
    logic [2:0] ind_pol_low_r;
    logic [2:0] event_channel_select_r;
    logic [2:0] pin_level_polarity_r;
    logic [2:0] event_oe_r;
    logic [2:0] pin_driver_type_r;
    logic [2:0] pin_dir_r;
    logic [2:0] pin_dout_r;
    logic [2:0] int_sts_r;
    logic [2:0] int_msk_r;
    logic strap_done_r;
    logic [31:0] rdata_nxt;
    logic acc_r;

    wire logic req = (avs_read_i | avs_write_i) & ~acc_r;
    wire logic wr = avs_write_i & ~acc_r;
    wire logic rd = avs_read_i & ~acc_r;
    wire logic be_lo = avs_byteenable_i[0];
    wire logic be_b1 = avs_byteenable_i[1];
    wire logic be_b2 = avs_byteenable_i[2];
    wire logic be_b3 = avs_byteenable_i[3];

    // one wait cycle per access: answered on the second edge
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_r <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else begin
            acc_r <= req;
            avs_waitrequest_o <= ~req;
        end
    end

    // straps caught by a clock after release, never through the async reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_done_r <= 1'b0;
            ind_pol_low_r <= `GLPC_RST3;
            indicator_function_sel_r <= `GLPC_RST3;
            indicator_enable_r <= `GLPC_RST3;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            ind_pol_low_r <= indicator_polarity_strap_i;
            indicator_function_sel_r <= indicator_function_strap_i;
            indicator_enable_r <= indicator_enable_strap_i;
        end else if (wr && avs_address_i == `GLPC_OFS_IND_CFG) begin
            if (be_b1) begin
                indicator_function_sel_r <= avs_writedata_i[`GLPC_IND_FN_LSB +: 3];
            end
            if (be_lo) begin
                indicator_enable_r <= avs_writedata_i[`GLPC_IND_EN_LSB +: 3];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_channel_select_r <= `GLPC_RST3;
            pin_level_polarity_r <= `GLPC_RST3;
            event_oe_r <= `GLPC_RST3;
        end else if (wr && avs_address_i == `GLPC_OFS_PIN_CFG) begin
            if (be_b3) begin
                event_channel_select_r <= avs_writedata_i[`GLPC_CHSEL_LSB +: 3];
            end
            if (be_b2) begin
                pin_level_polarity_r <= avs_writedata_i[`GLPC_POL_LSB +: 3];
            end
            if (be_b1) begin
                event_oe_r <= avs_writedata_i[`GLPC_EVT_OE_LSB +: 3];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_driver_type_r <= `GLPC_RST3;
            pin_dir_r <= `GLPC_RST3;
            pin_dout_r <= `GLPC_RST3;
            int_msk_r <= `GLPC_RST3;
        end else if (wr) begin
            if (avs_address_i == `GLPC_OFS_PIN_IO) begin
                if (be_lo) begin
                    pin_driver_type_r <= avs_writedata_i[`GLPC_DRV_LSB +: 3];
                end
                if (be_b1) begin
                    pin_dir_r <= avs_writedata_i[`GLPC_DIR_LSB +: 3];
                end
                if (be_b2) begin
                    pin_dout_r <= avs_writedata_i[`GLPC_DOUT_LSB +: 3];
                end
            end
            if (avs_address_i == `GLPC_OFS_INT_MSK && be_lo) begin
                int_msk_r <= avs_writedata_i[2:0];
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        rdata_nxt = `GLPC_RST32;
        case (avs_address_i)
            `GLPC_OFS_IND_CFG: begin
                rdata_nxt[`GLPC_IND_FN_LSB +: 3] = indicator_function_sel_r;
                rdata_nxt[`GLPC_IND_EN_LSB +: 3] = indicator_enable_r;
            end
            `GLPC_OFS_PIN_CFG: begin
                rdata_nxt[`GLPC_CHSEL_LSB +: 3] = event_channel_select_r;
                rdata_nxt[`GLPC_POL_LSB +: 3] = pin_level_polarity_r;
                rdata_nxt[`GLPC_EVT_OE_LSB +: 3] = event_oe_r;
            end
            `GLPC_OFS_INT_STS: rdata_nxt[2:0] = int_sts_r;
            `GLPC_OFS_INT_MSK: rdata_nxt[2:0] = int_msk_r;
            `GLPC_OFS_PIN_IO: begin
                rdata_nxt[`GLPC_DRV_LSB +: 3] = pin_driver_type_r;
                rdata_nxt[`GLPC_DIR_LSB +: 3] = pin_dir_r;
                rdata_nxt[`GLPC_DOUT_LSB +: 3] = pin_dout_r;
            end
            default: rdata_nxt = `GLPC_RST32;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= `GLPC_RST32;
        end else if (rd) begin
            avs_readdata_o <= rdata_nxt;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    logic [2:0] lvl_hit;
    logic sts_rd;
    assign lvl_hit = ~(pin_i ^ pin_level_polarity_r) & ~indicator_enable_r;
    assign sts_rd = rd && avs_address_i == `GLPC_OFS_INT_STS;

    // a level present during the clearing read sets again: set wins
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_sts_r <= `GLPC_RST3;
            irq_o <= 1'b0;
        end else begin
            int_sts_r <= (sts_rd ? 3'h0 : int_sts_r) | lvl_hit;
            irq_o <= |(((sts_rd ? 3'h0 : int_sts_r) | lvl_hit) & int_msk_r);
        end
    end

    // ************************************************************
    // link indications
    // ************************************************************
    logic act_p;
    logic col_p;
    glpc_pulse #(.HOLD_CYC(ACT_CYC)) u_act (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .event_i(activity_i & link_up_i),
        .pulse_o(act_p)
    );
    glpc_pulse #(.HOLD_CYC(ACT_CYC)) u_col (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .event_i(collision_i & link_up_i & ~full_duplex_i),
        .pulse_o(col_p)
    );

    logic lk, l100, l10, lact, l100a, l10a, fdc, spd, actv;
    assign lk = link_up_i;
    assign l100 = lk & speed_100_i;
    assign l10 = lk & ~speed_100_i;
    assign actv = lk & act_p;
    assign lact = lk & ~act_p;
    assign l100a = l100 & ~act_p;
    assign l10a = l10 & ~act_p;
    assign fdc = lk & (full_duplex_i | col_p);
    assign spd = l100;

    logic [2:0] ind_act;
    always_comb begin
        case (indicator_function_sel_r)
            3'h0: ind_act = {lact, fdc, spd};
            3'h1: ind_act = {l100a, fdc, l10a};
            3'h2: ind_act = {actv, lk, spd};
            3'h3: ind_act = {actv, lk, fdc};
            3'h4: ind_act = {actv, l10, l100};
            default: ind_act = 3'h0;
        endcase
    end

    // ************************************************************
    // per pin output mux
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            logic ev;
            logic val;
            logic oe;
            assign ev = event_channel_select_r[g] ? event_chan_b_i[g] : event_chan_a_i[g];
            always_comb begin
                if (indicator_enable_r[g]) begin
                    // open-drain style: drive only while active
                    val = ~ind_pol_low_r[g];
                    oe = ind_act[g];
                end else if (event_oe_r[g]) begin
                    val = ev ? pin_level_polarity_r[g] : ~pin_level_polarity_r[g];
                    oe = pin_driver_type_r[g] | ~val;
                end else begin
                    val = pin_dout_r[g];
                    oe = pin_dir_r[g] & (pin_driver_type_r[g] | ~val);
                end
            end
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    pin_o[g] <= 1'b0;
                    pin_oe_o[g] <= 1'b0;
                    pin_pullup_en_o[g] <= 1'b1;
                    pin_inbuf_en_o[g] <= 1'b1;
                    timer_clear_o[g] <= 1'b0;
                end else begin
                    pin_o[g] <= val;
                    pin_oe_o[g] <= oe;
                    pin_pullup_en_o[g] <= ~indicator_enable_r[g];
                    pin_inbuf_en_o[g] <= ~indicator_enable_r[g];
                    timer_clear_o[g] <= ~indicator_enable_r[g]
                        & (pin_i[g] == pin_level_polarity_r[g]);
                end
            end
        end
    endgenerate

    // ************************************************************
    // checks
    // ************************************************************
    property p_ind_pullup;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        indicator_enable_r[0] |=> !pin_pullup_en_o[0] && !pin_inbuf_en_o[0];
    endproperty
    a_ind_pullup: assert property (p_ind_pullup) else $error("pull-up on indicator pin");

    property p_int_set;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!indicator_enable_r[1] && pin_i[1] == pin_level_polarity_r[1]) |=> int_sts_r[1];
    endproperty
    a_int_set: assert property (p_int_set) else $error("status not set");

    property p_evt_out;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!indicator_enable_r[2] && event_oe_r[2] && pin_driver_type_r[2])
            |=> pin_oe_o[2];
    endproperty
    a_evt_out: assert property (p_evt_out) else $error("event pin not output");

    property p_evt_lvl;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!indicator_enable_r[0] && event_oe_r[0] && !event_channel_select_r[0]
            && event_chan_a_i[0]) |=> pin_o[0] == $past(pin_level_polarity_r[0]);
    endproperty
    a_evt_lvl: assert property (p_evt_lvl) else $error("event level wrong");

    property p_wait;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("no answer");

    property p_rsvd;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !avs_waitrequest_o |-> avs_readdata_o[31:27] == 5'h0 && avs_readdata_o[7:3] == 5'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

    property p_strap;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(strap_done_r) |-> indicator_enable_r == $past(indicator_enable_strap_i);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded");

    property p_pol_fixed;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        strap_done_r |=> $stable(ind_pol_low_r);
    endproperty
    a_pol_fixed: assert property (p_pol_fixed) else $error("indicator polarity moved");
endmodule : glpc_top

/* File: hdl/glpc_params.svh */
// glpc_params.svh: offsets, field positions, reset values and timing figures
// for the shared pin configuration block; definitions only
`ifndef GLPC_PARAMS_SVH
`define GLPC_PARAMS_SVH

// ************************************************************
// register map (byte addresses)
// ************************************************************
`define GLPC_OFS_IND_CFG 12'h1BC
`define GLPC_OFS_PIN_CFG 12'h1E0
`define GLPC_OFS_INT_STS 12'h1F0
`define GLPC_OFS_INT_MSK 12'h1F4
`define GLPC_OFS_PIN_IO 12'h1F8

// ************************************************************
// field positions
// ************************************************************
`define GLPC_IND_EN_LSB 0
`define GLPC_IND_FN_LSB 8
`define GLPC_EVT_OE_LSB 8
`define GLPC_POL_LSB 16
`define GLPC_CHSEL_LSB 24
`define GLPC_DRV_LSB 0
`define GLPC_DIR_LSB 8
`define GLPC_DOUT_LSB 16

// ************************************************************
// reset values and timing
// ************************************************************
`define GLPC_RST3 3'h0
`define GLPC_RST32 32'h0000_0000
`define GLPC_CLK_MHZ 100
`define GLPC_ACT_MS 80

`endif

/* File: hdl/glpc_pkg.sv */
// glpc_pkg.sv: types shared by the pin configuration block
// assumes glpc_params.svh holds all numeric constants
package glpc_pkg;
    typedef enum logic [1:0] {GLPC_IDLE, GLPC_ON, GLPC_OFF} glpc_pulse_e;
    typedef logic [2:0] glpc_pins_t;
endpackage : glpc_pkg

/* File: hdl/glpc_pulse.sv */
// glpc_pulse.sv: stretches an activity event into an on window followed by
// an off window of at least the same length
// assumes one clock domain and an event input synchronous to it
`timescale 1ns/10ps
`include "glpc_params.svh"
module glpc_pulse #(
    parameter int unsigned HOLD_CYC = `GLPC_ACT_MS * 1000 * `GLPC_CLK_MHZ
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // event in, stretched level out
    input wire logic event_i,
    output logic pulse_o
);
    initial begin
        if (HOLD_CYC < 1) $error("glpc_pulse: HOLD_CYC must be at least one");
    end

    glpc_pkg::glpc_pulse_e state_r;
    logic [31:0] cnt_r;

    // off window enforces the gap so back to back activity stays visible
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= glpc_pkg::GLPC_IDLE;
            cnt_r <= 32'h0;
        end else begin
            case (state_r)
                glpc_pkg::GLPC_IDLE: begin
                    if (event_i) begin
                        state_r <= glpc_pkg::GLPC_ON;
                        cnt_r <= 32'h0;
                    end
                end
                glpc_pkg::GLPC_ON: begin
                    if (cnt_r == HOLD_CYC - 1) begin
                        state_r <= glpc_pkg::GLPC_OFF;
                        cnt_r <= 32'h0;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                glpc_pkg::GLPC_OFF: begin
                    if (cnt_r == HOLD_CYC - 1) begin
                        state_r <= glpc_pkg::GLPC_IDLE;
                        cnt_r <= 32'h0;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                default: begin
                    state_r <= glpc_pkg::GLPC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= (state_r == glpc_pkg::GLPC_ON);
        end
    end
endmodule : glpc_pulse

/* File: sim/glpc_tb.sv */
// glpc_tb.sv: self-checking bench for the shared pin configuration block
// assumes glpc_top with an avalon-mm slave answering one cycle after a request
`timescale 1ns/10ps
`include "glpc_params.svh"
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp); end end

module testbench;
    // ************************************************************
    // settings and signals
    // ************************************************************
    localparam int unsigned ACT = 8;
    localparam logic [2:0] FN_STRAP = 3'h2;
    localparam logic [2:0] EN_STRAP = 3'h5;
    localparam logic [2:0] POL_STRAP = 3'h2;
    logic clk_sys_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
    logic [11:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, d;
    logic [3:0] avs_byteenable_i;
    logic link_up_i, speed_100_i, full_duplex_i, activity_i, collision_i;
    logic [2:0] event_chan_a_i, event_chan_b_i, timer_clear_o, pin_i, pin_o, pin_oe_o;
    logic [2:0] pin_pullup_en_o, pin_inbuf_en_o, ev, lvl;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int cnt;

    glpc_top #(.ACT_CYC(ACT)) DUT (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
        .indicator_function_strap_i(FN_STRAP), .indicator_enable_strap_i(EN_STRAP),
        .indicator_polarity_strap_i(POL_STRAP),
        .link_up_i(link_up_i), .speed_100_i(speed_100_i), .full_duplex_i(full_duplex_i),
        .activity_i(activity_i), .collision_i(collision_i),
        .event_chan_a_i(event_chan_a_i), .event_chan_b_i(event_chan_b_i),
        .timer_clear_o(timer_clear_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .pin_pullup_en_o(pin_pullup_en_o), .pin_inbuf_en_o(pin_inbuf_en_o)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ************************************************************
    // verdict, timeout and read monitor
    // ************************************************************
    task automatic finish_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // bit 32 of a note says whether the returned data is compared
    always @(posedge clk_sys_i) begin
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("unexpected at %0t: read answer with no note", $time);
            end else begin
                e = exp_q.pop_front();
                if (e[32]) `CHK(avs_readdata_o, e[31:0], "read data")
            end
        end
    end

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] be);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        if (wr) avs_write_i <= 1'b1;
        else avs_read_i <= 1'b1;
        // no local limit: only the bench timeout ends a stuck wait
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        acc(1'b1, a, wd, 4'hF);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic chk);
        exp_q.push_back({chk, ex});
        acc(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
    endtask : settle

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        reset_n_i = 1'b0;
        {avs_read_i, avs_write_i} = 2'b00;
        avs_address_i = 12'h000;
        avs_writedata_i = 32'h0000_0000;
        avs_byteenable_i = 4'h0;
        {link_up_i, speed_100_i, full_duplex_i, activity_i, collision_i} = 5'h00;
        event_chan_a_i = 3'h0;
        event_chan_b_i = 3'h0;
        pin_i = 3'h6;
        void'($urandom(98));
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        // reset values and an unmapped place
        rd(`GLPC_OFS_IND_CFG, {21'h0, FN_STRAP, 5'h0, EN_STRAP}, 1'b1);
        rd(`GLPC_OFS_PIN_CFG, 32'h0000_0000, 1'b1);
        rd(12'h100, 32'h0000_0000, 1'b1);
        // random fields back to back, reserved bits dropped
        repeat (4) begin
            d = $urandom();
            wr(`GLPC_OFS_IND_CFG, d);
            rd(`GLPC_OFS_IND_CFG, d & 32'h0000_0707, 1'b1);
            wr(`GLPC_OFS_PIN_CFG, d);
            rd(`GLPC_OFS_PIN_CFG, d & 32'h0707_0700, 1'b1);
        end
        wr(12'h104, 32'hFFFF_FFFF);
        rd(12'h104, 32'h0000_0000, 1'b1);
        // lane 0 only: the function field must keep its value
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0300);
        acc(1'b1, `GLPC_OFS_IND_CFG, 32'h0000_0405, 4'h1);
        rd(`GLPC_OFS_IND_CFG, 32'h0000_0305, 1'b1);
        // indicators: pin 1 shows link, others stay gpio inputs
        wr(`GLPC_OFS_PIN_CFG, 32'h0000_0000);
        wr(`GLPC_OFS_PIN_IO, 32'h0000_0000);
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0202);
        link_up_i <= 1'b1;
        settle();
        `CHK(pin_oe_o, 3'h2, "link indicator drive")
        `CHK(pin_o[1], ~POL_STRAP[1], "active level")
        `CHK(pin_pullup_en_o, 3'h5, "pull-ups")
        `CHK(pin_inbuf_en_o, 3'h5, "input buffers")
        link_up_i <= 1'b0;
        settle();
        `CHK(pin_oe_o, 3'h0, "no link, undriven")
        // function 4: pin 1 is 10 Mbps link, pin 0 is 100 Mbps link
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0403);
        link_up_i <= 1'b1;
        speed_100_i <= 1'b0;
        settle();
        `CHK(pin_oe_o[1:0], 2'h2, "10 link shown")
        speed_100_i <= 1'b1;
        settle();
        `CHK(pin_oe_o[1:0], 2'h1, "100 link shown")
        // functions 1, 0, 3 and a reserved code, every pin an indicator
        full_duplex_i <= 1'b1;
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0107);
        settle();
        `CHK(pin_oe_o, 3'h6, "function 1 indications")
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0007);
        settle();
        `CHK(pin_oe_o, 3'h7, "function 0 indications")
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0307);
        settle();
        `CHK(pin_oe_o, 3'h3, "function 3 indications")
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0507);
        settle();
        `CHK(pin_oe_o, 3'h0, "reserved function inactive")
        full_duplex_i <= 1'b0;
        // activity stretch on pin 2 with function 2
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0204);
        activity_i <= 1'b1;
        @(posedge clk_sys_i);
        activity_i <= 1'b0;
        cnt = 0;
        while (pin_oe_o[2] !== 1'b1 && cnt < 10) begin
            @(posedge clk_sys_i);
            cnt++;
        end
        cnt = 0;
        while (pin_oe_o[2] === 1'b1 && cnt < 40) begin
            @(posedge clk_sys_i);
            cnt++;
        end
        `CHK(cnt >= ACT && cnt <= ACT + 1, 1'b1, "activity on window")
        activity_i <= 1'b1;
        cnt = 0;
        while (pin_oe_o[2] !== 1'b1 && cnt < 40) begin
            @(posedge clk_sys_i);
            cnt++;
        end
        `CHK(cnt >= ACT, 1'b1, "activity off window")
        activity_i <= 1'b0;
        // time events on all pins, push-pull then open-drain
        wr(`GLPC_OFS_IND_CFG, 32'h0000_0000);
        wr(`GLPC_OFS_PIN_IO, 32'h0000_0007);
        wr(`GLPC_OFS_PIN_CFG, 32'h0205_0700);
        repeat (6) begin
            event_chan_a_i <= 3'($urandom());
            event_chan_b_i <= 3'($urandom());
            settle();
            ev = (event_chan_b_i & 3'h2) | (event_chan_a_i & 3'h5);
            lvl = (ev & 3'h5) | (~ev & 3'h2);
            `CHK(pin_oe_o, 3'h7, "event pins drive")
            `CHK(pin_o, lvl, "event level and channel")
        end
        wr(`GLPC_OFS_PIN_IO, 32'h0000_0000);
        settle();
        `CHK(pin_oe_o, ~lvl, "open-drain event drive")
        // level interrupts: pin 0 high, pins 1 and 2 low trigger
        wr(`GLPC_OFS_PIN_CFG, 32'h0001_0000);
        wr(`GLPC_OFS_INT_MSK, 32'h0000_0001);
        pin_i <= 3'h6;
        settle();
        rd(`GLPC_OFS_INT_STS, 32'h0000_0000, 1'b0);
        rd(`GLPC_OFS_INT_STS, 32'h0000_0000, 1'b1);
        pin_i <= 3'h7;
        settle();
        `CHK(irq_o, 1'b1, "unmasked status raises irq")
        `CHK(timer_clear_o, 3'h1, "timer clear level")
        rd(`GLPC_OFS_INT_STS, 32'h0000_0001, 1'b1);
        pin_i <= 3'h6;
        settle();
        rd(`GLPC_OFS_INT_STS, 32'h0000_0001, 1'b1);
        rd(`GLPC_OFS_INT_STS, 32'h0000_0000, 1'b1);
        settle();
        `CHK(irq_o, 1'b0, "irq drops after clear")
        pin_i <= 3'h4;
        settle();
        `CHK(irq_o, 1'b0, "masked status keeps irq low")
        `CHK(timer_clear_o, 3'h2, "timer clear low level")
        rd(`GLPC_OFS_INT_STS, 32'h0000_0002, 1'b1);
        settle();
        finish_test();
    end
endmodule : testbench
